// ===== core/pmic_defines.vh
// Constants for the per-port MAC ingress control block.
// Assumes a 100 MHz core clock and a 32-bit APB register bus.
`ifndef PMIC_DEFINES_VH
`define PMIC_DEFINES_VH

// Register indices; byte address is four times the index
`define PMIC_IDX_STORM      12'h400
`define PMIC_IDX_BPPASS     12'h401
`define PMIC_IDX_LIMSETUP   12'h403
`define PMIC_IDX_PRIO0      12'h410
`define PMIC_IDX_PRIO7      12'h417

// Writable bit masks and reset values
`define PMIC_MASK_STORM     8'h0B
`define PMIC_MASK_BPPASS    8'hBF
`define PMIC_MASK_LIMSETUP  8'h7F
`define PMIC_RST_STORM      8'h00
`define PMIC_RST_BPPASS     8'h00
`define PMIC_RST_LIMSETUP   8'h00
`define PMIC_RST_PRIO       7'h00

// Field positions
`define PMIC_B_STORMEN      1
`define PMIC_B_BPEN         3
`define PMIC_B_PASSALL      0
`define PMIC_B_PORTMODE     6
`define PMIC_B_PPS          5
`define PMIC_B_LIMFC        4
`define PMIC_B_MODEHI       3
`define PMIC_B_MODELO       2
`define PMIC_B_IFG          1
`define PMIC_B_PRE          0

// Count classes
`define PMIC_CNT_ALL        2'h0
`define PMIC_CNT_BMF        2'h1
`define PMIC_CNT_BM         2'h2
`define PMIC_CNT_B          2'h3

// Accounting bytes per frame
`define PMIC_IFG_BYTES      14'h000C
`define PMIC_PRE_BYTES      14'h0008

// Accounting window
`define PMIC_CLK_MHZ        100
`define PMIC_WINDOW_US      1000
`define PMIC_WINDOW_CYC     (`PMIC_WINDOW_US * `PMIC_CLK_MHZ)

`endif

// ===== core/pmic_limit_mem.v
// Pending and active per-priority ingress limit codes.
// Assumes the bus side gives one-cycle write and read strobes.
`timescale 1ns/1ps
`include "pmic_defines.vh"

module pmic_limit_mem (
	input  wire        clk,
	input  wire        sys_rst,
	input  wire        wrEn,
	input  wire [2:0]  wrAddr,
	input  wire [6:0]  wrData,
	input  wire        rdEn,
	input  wire [2:0]  rdAddr,
	output reg  [6:0]  rdData,
	output reg  [55:0] activeCodes
);
	reg [6:0] pending [0:7];
	integer   i;

	// Writes park in pending; a priority 7 write commits all eight at once
	always @(posedge clk) begin
		if (sys_rst) begin
			for (i = 0; i < 8; i = i + 1) begin
				pending[i] <= `PMIC_RST_PRIO;
			end
			activeCodes <= 56'h00000000000000;
			rdData      <= 7'h00;
		end else begin
			if (wrEn) begin
				pending[wrAddr] <= wrData;
			end
			if (wrEn && wrAddr == 3'h7) begin
				for (i = 0; i < 7; i = i + 1) begin
					activeCodes[i*7 +: 7] <= pending[i];
				end
				activeCodes[55:49] <= wrData;
			end
			if (rdEn) begin
				rdData <= pending[rdAddr];
			end
		end
	end
endmodule

// ===== core/pmic_top.v
// Per-port MAC ingress control: registers, frame verdict, storm and rate limiting.
// Assumes frame status arrives from the receive MAC on the same clock as a
// one-cycle end-of-frame strobe, and duplex and flow enables are same-clock levels.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`include "pmic_defines.vh"

module pmic_top #(
	parameter integer WINDOW_CYC   = `PMIC_WINDOW_CYC,
	parameter integer STORM_THRESH = 100,
	parameter integer RATE_SCALE   = 1000
) (
	input  wire        clk,
	input  wire        sys_rst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [15:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        frmEnd,
	input  wire [13:0] frmLen,
	input  wire        frmBad,
	input  wire        frmBcast,
	input  wire        frmMcast,
	input  wire        frmFlood,
	input  wire        frmPause,
	input  wire [2:0]  frmPrio,
	input  wire        duplexFull,
	input  wire        portFlowEn,
	input  wire        pauseFilterEn,
	input  wire        fabricCongested,
	output reg         vrdValid,
	output reg         vrdForward,
	output reg         vrdMirror,
	output reg         vrdDrop,
	output reg         pauseReq,
	output reg         jamReq,
	output reg         stormActive
);
	reg  [7:0]  stormCtrl;
	reg  [7:0]  bpPassCtrl;
	reg  [7:0]  limSetup;
	reg  [16:0] winCnt;
	reg         winTick;
	reg  [15:0] stormCnt;
	reg  [23:0] acc [0:7];
	reg         overrun;
	integer     k;

	wire [55:0] activeCodes;
	wire [6:0]  memRdData;
	wire [11:0] regIdx     = paddr[13:2];
	wire        setupPh    = psel && !penable;
	wire        wrCommit   = psel && penable && pready && pwrite;
	wire        idxIsPrio  = regIdx[11:3] == `PMIC_IDX_PRIO0 >> 3;
	wire        memWr      = wrCommit && idxIsPrio && paddr[1:0] == 2'h0;
	wire        memRd      = setupPh && !pwrite && idxIsPrio;

	// Bus address decode is shared by read, error and register write paths; limit memory writes decode idxIsPrio and paddr[1:0] only
	function mapped;
		input [15:0] a;
		begin
			mapped = a[1:0] == 2'h0 && a[15:14] == 2'h0 &&
				(a[13:2] == `PMIC_IDX_STORM || a[13:2] == `PMIC_IDX_BPPASS ||
				 a[13:2] == `PMIC_IDX_LIMSETUP || a[13:5] == `PMIC_IDX_PRIO0 >> 3);
		end
	endfunction

	// Is this frame in the class chosen for counting
	function counted;
		input [1:0] mode;
		input       bc;
		input       mc;
		input       fl;
		begin
			case (mode)
				`PMIC_CNT_ALL: counted = 1'b1;
				`PMIC_CNT_BMF: counted = bc || mc || fl;
				`PMIC_CNT_BM:  counted = bc || mc;
				`PMIC_CNT_B:   counted = bc;
				default:       counted = 1'b0;
			endcase
		end
	endfunction

	// Accounting units for one frame: one packet, or bits incl. optional overhead
	function [23:0] units;
		input [7:0]  setup;
		input [13:0] len;
		reg   [13:0] bytes;
		begin
			bytes = len;
			if (setup[`PMIC_B_IFG]) begin
				bytes = bytes + `PMIC_IFG_BYTES;
			end
			if (setup[`PMIC_B_PRE] && !setup[`PMIC_B_PPS]) begin
				bytes = bytes + `PMIC_PRE_BYTES;
			end
			if (setup[`PMIC_B_PPS]) begin
				units = 24'h000001;
			end else begin
				units = {7'h00, bytes, 3'h0};
			end
		end
	endfunction

	pmic_limit_mem i_pmic_limit_mem (
		.clk         (clk),
		.sys_rst     (sys_rst),
		.wrEn        (memWr),
		.wrAddr      (regIdx[2:0]),
		.wrData      (pwdata[6:0]),
		.rdEn        (memRd),
		.rdAddr      (regIdx[2:0]),
		.rdData      (memRdData),
		.activeCodes (activeCodes)
	);

	// APB slave: one wait state so the limit memory read data can settle
	always @(posedge clk) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready <= psel && penable && !pready;
			if (psel && penable && !pready) begin
				pslverr <= !mapped(paddr);
				prdata  <= 32'h00000000;
				if (!pwrite && mapped(paddr)) begin
					case (regIdx)
						`PMIC_IDX_STORM:    prdata <= {24'h000000, stormCtrl};
						`PMIC_IDX_BPPASS:   prdata <= {24'h000000, bpPassCtrl};
						`PMIC_IDX_LIMSETUP: prdata <= {24'h000000, limSetup};
						default:            prdata <= {25'h0000000, memRdData};
					endcase
				end
			end
		end
	end

	// Register writes; masks keep read-only reserved bits at reset value
	always @(posedge clk) begin
		if (sys_rst) begin
			stormCtrl  <= `PMIC_RST_STORM;
			bpPassCtrl <= `PMIC_RST_BPPASS;
			limSetup   <= `PMIC_RST_LIMSETUP;
		end else if (wrCommit && mapped(paddr)) begin
			case (regIdx)
				`PMIC_IDX_STORM:
					stormCtrl <= pwdata[7:0] & `PMIC_MASK_STORM;
				`PMIC_IDX_BPPASS:
					bpPassCtrl <= pwdata[7:0] & `PMIC_MASK_BPPASS;
				`PMIC_IDX_LIMSETUP:
					limSetup <= pwdata[7:0] & `PMIC_MASK_LIMSETUP;
				default: ;
			endcase
		end
	end

	// Window divider: one-cycle tick that restarts storm and rate accounting
	always @(posedge clk) begin
		if (sys_rst) begin
			winCnt  <= 17'h00000;
			winTick <= 1'b0;
		end else if (winCnt == WINDOW_CYC[16:0] - 17'h00001) begin
			winCnt  <= 17'h00000;
			winTick <= 1'b1;
		end else begin
			winCnt  <= winCnt + 17'h00001;
			winTick <= 1'b0;
		end
	end

	// Frame verdict, storm and rate accounting, all decided at end of frame
	reg  [2:0]  slot;
	reg  [23:0] sum;
	reg  [23:0] lim;
	reg         isCounted;
	reg         over;
	always @* begin
		slot      = limSetup[`PMIC_B_PORTMODE] ? 3'h0 : frmPrio;
		lim       = activeCodes[slot*7 +: 7] * RATE_SCALE[16:0];
		isCounted = counted(limSetup[`PMIC_B_MODEHI:`PMIC_B_MODELO],
			frmBcast, frmMcast, frmFlood);
		sum       = acc[slot] + units(limSetup, frmLen);
		over      = isCounted && lim != 24'h000000 && sum > lim;
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			vrdValid    <= 1'b0;
			vrdForward  <= 1'b0;
			vrdMirror   <= 1'b0;
			vrdDrop     <= 1'b0;
			stormCnt    <= 16'h0000;
			stormActive <= 1'b0;
			overrun     <= 1'b0;
			for (k = 0; k < 8; k = k + 1) begin
				acc[k] <= 24'h000000;
			end
		end else begin
			vrdValid   <= frmEnd;
			vrdForward <= 1'b0;
			vrdMirror  <= 1'b0;
			vrdDrop    <= 1'b0;
			if (winTick) begin
				stormCnt    <= 16'h0000;
				stormActive <= 1'b0;
				overrun     <= 1'b0;
				for (k = 0; k < 8; k = k + 1) begin
					acc[k] <= 24'h000000;
				end
			end else if (frmEnd) begin
				if (frmBad) begin
					// Bad frames never reach normal forwarding
					vrdMirror <= bpPassCtrl[`PMIC_B_PASSALL];
					vrdDrop   <= !bpPassCtrl[`PMIC_B_PASSALL];
				end else if (frmPause && pauseFilterEn) begin
					vrdDrop <= 1'b1;
				end else if (frmBcast && stormActive && stormCtrl[`PMIC_B_STORMEN]) begin
					vrdDrop <= 1'b1;
				end else if (over) begin
					vrdDrop <= 1'b1;
					overrun <= 1'b1;
				end else begin
					vrdForward <= 1'b1;
					if (isCounted) begin
						acc[slot] <= sum;
					end
				end
				// Storm count only runs while protection is on
				if (!frmBad && frmBcast && stormCtrl[`PMIC_B_STORMEN]) begin
					if (stormCnt != 16'hFFFF) begin
						stormCnt <= stormCnt + 16'h0001;
					end
					if (stormCnt + 16'h0001 >= STORM_THRESH[15:0]) begin
						stormActive <= 1'b1;
					end
				end
			end
		end
	end

	// Flow control toward the partner: pause in full duplex, jam in half
	wire limFc = limSetup[`PMIC_B_LIMFC] && overrun && portFlowEn;
	always @(posedge clk) begin
		if (sys_rst) begin
			pauseReq <= 1'b0;
			jamReq   <= 1'b0;
		end else begin
			pauseReq <= duplexFull && ((portFlowEn && fabricCongested) || limFc);
			jamReq   <= !duplexFull &&
				((bpPassCtrl[`PMIC_B_BPEN] && fabricCongested) || limFc);
		end
	end
endmodule

// ===== tb/pmic_monitor.sv
// Checker on the ports of the ingress control block.
// Assumes it is bound into pmic_top.
`timescale 1ns/1ps
module pmic_monitor (
	input wire		clk,
	input wire		sys_rst,
	input wire [31:0]	prdata,
	input wire		pready,
	input wire		frmEnd,
	input wire		frmBad,
	input wire		frmPause,
	input wire		duplexFull,
	input wire		portFlowEn,
	input wire		pauseFilterEn,
	input wire		vrdValid,
	input wire		vrdForward,
	input wire		vrdMirror,
	input wire		vrdDrop,
	input wire		pauseReq,
	input wire		jamReq
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Frames that must never take the normal forwarding path
	sequence badFrame; frmEnd && frmBad; endsequence
	sequence cutPause; frmEnd && frmPause && pauseFilterEn; endsequence
	// A window tick may leave a verdict empty, so only extra bits are wrong
	verdict_one_a: assert property (frmEnd |=> vrdValid &&
		$onehot0({vrdForward, vrdMirror, vrdDrop})) else $error("bad verdict");
	verdict_idle_a: assert property (!vrdValid |-> !(vrdForward || vrdMirror || vrdDrop))
		else $error("stray verdict");
	bad_no_fwd_a: assert property (badFrame |=> !vrdForward)
		else $error("bad frame forwarded");
	mirror_cause_a: assert property (vrdMirror |-> $past(frmBad))
		else $error("good frame mirrored");
	pause_cut_a: assert property (cutPause |=> !vrdForward)
		else $error("pause frame forwarded");
	jam_full_a: assert property (duplexFull |=> !jamReq)
		else $error("jam in full duplex");
	pause_flow_a: assert property (!portFlowEn |=> !pauseReq)
		else $error("pause without flow enable");
	read_upper_a: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
endmodule

bind pmic_top pmic_monitor i_pmic_monitor (.clk, .sys_rst, .prdata, .pready, .frmEnd,
	.frmBad, .frmPause, .duplexFull, .portFlowEn, .pauseFilterEn, .vrdValid, .vrdForward,
	.vrdMirror, .vrdDrop, .pauseReq, .jamReq);

// ===== tb/pmic_link_partner.sv
// Link partner model: hands received frames to the ingress control block.
// Assumes frame status is sampled only with the one-cycle end strobe.
`timescale 1ns/1ps
module pmic_link_partner (
	input wire		clk,
	output reg		frmEnd,
	output wire [13:0]	frmLen,
	output wire		frmBad,
	output wire		frmBcast,
	output wire		frmMcast,
	output wire		frmFlood,
	output wire		frmPause,
	output wire [2:0]	frmPrio
);
	reg [21:0]	fields = 22'h0;
	// Lines carry the inverse once the strobe falls, never a stale copy
	assign {frmBad, frmBcast, frmMcast, frmFlood, frmPause, frmPrio, frmLen} = fields;
	initial frmEnd = 1'b0;
	// One frame; strobes from back-to-back calls are at least two cycles apart
	task send(input [4:0] cls, input [2:0] prio, input [13:0] len);
		begin
			@(posedge clk);
			frmEnd <= 1'b1;
			fields <= {cls, prio, len};
			@(posedge clk);
			frmEnd <= 1'b0;
			fields <= ~fields;
		end
	endtask
endmodule

// ===== tb/port_mac_ingress_control_tb.sv
// Self-checking bench for the per-port MAC ingress control block.
// Assumes short storm and rate parameters; the bench is the APB master.
`timescale 1ns/1ps
module port_mac_ingress_control_tb;
	localparam [4:0] BAD = 5'h10, BC = 5'h08, PS = 5'h01;
	localparam [2:0] FWD = 3'h4, MIR = 3'h2, DRP = 3'h1;
	localparam logic [15:0] REGA [4] = '{16'h1000, 16'h1004, 16'h100C, 16'h1040};
	localparam logic [7:0] REGM [4] = '{8'h0B, 8'hBF, 8'h7F, 8'h7F};
	reg		clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	reg [15:0]	paddr = 16'h0;
	reg [31:0]	pwdata = 32'h0, rdVal;
	reg		duplexFull = 1'b1, portFlowEn = 1'b0, pauseFilterEn = 1'b0;
	reg		fabricCongested = 1'b0, rdErr;
	wire [31:0]	prdata;
	wire [13:0]	frmLen;
	wire [2:0]	frmPrio;
	wire		pready, pslverr, frmEnd, frmBad, frmBcast, frmMcast, frmFlood, frmPause;
	wire		vrdValid, vrdForward, vrdMirror, vrdDrop, pauseReq, jamReq, stormActive;
	integer		numErrors = 0, samplesChecked = 0, i, k, m;

	// Free-running 100 MHz clock
	initial forever #5 clk = ~clk;

	pmic_top #(.WINDOW_CYC(50000), .STORM_THRESH(4), .RATE_SCALE(64)) i_pmic_top (.clk,
		.sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.frmEnd, .frmLen, .frmBad, .frmBcast, .frmMcast, .frmFlood, .frmPause, .frmPrio,
		.duplexFull, .portFlowEn, .pauseFilterEn, .fabricCongested, .vrdValid,
		.vrdForward, .vrdMirror, .vrdDrop, .pauseReq, .jamReq, .stormActive);
	pmic_link_partner i_pmic_link_partner (.clk, .frmEnd, .frmLen, .frmBad, .frmBcast,
		.frmMcast, .frmFlood, .frmPause, .frmPrio);

	// Every comparison is counted; a mismatch is shown at once
	task check(input [31:0] got, input [31:0] exp);
		begin
			samplesChecked = samplesChecked + 1;
			if (got !== exp) begin
				numErrors = numErrors + 1;
				$display("Error at %0t: got %h, expected %h", $time, got, exp);
			end
		end
	endtask
	task finishTest;
		begin
			$display("Checks %0d, errors %0d", samplesChecked, numErrors);
			if (numErrors == 0 && samplesChecked > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	// One transfer, held until pready is seen at a rising edge
	task apb(input wr, input [15:0] addr, input [7:0] data);
		begin
			@(posedge clk);
			psel <= 1'b1;
			pwrite <= wr;
			paddr <= addr;
			pwdata <= {24'h0, data};
			@(posedge clk);
			penable <= 1'b1;
			repeat (16) if (pready !== 1'b1) @(posedge clk);
			if (pready !== 1'b1) begin
				check(32'h0, 32'h1);
				finishTest;
			end
			rdVal = prdata;
			rdErr = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task doReset;
		begin
			sys_rst <= 1'b1;
			repeat (6) @(posedge clk);
			sys_rst <= 1'b0;
		end
	endtask
	// Verdict is taken at the edge after the one that judged the frame
	task frame(input [4:0] cls, input [2:0] prio, input [13:0] len, input [2:0] exp);
		begin
			i_pmic_link_partner.send(cls, prio, len);
			@(posedge clk);
			check({vrdValid, vrdForward, vrdMirror, vrdDrop}, {1'b1, exp});
		end
	endtask
	// Fresh limiter, priority 0 code 10 (640 units), one frame, then flow request
	task rate(input [7:0] setup, input [4:0] cls, input [2:0] prio, input [13:0] len,
		input lat, input [2:0] exp);
		reg fc;
		begin
			doReset;
			apb(1'b1, 16'h1040, 8'h0A);
			if (lat)
				apb(1'b1, 16'h105C, 8'h0A);
			apb(1'b1, 16'h100C, setup);
			frame(cls, prio, len, exp);
			@(posedge clk);
			fc = exp[0] & setup[4] & portFlowEn;
			check({pauseReq, jamReq}, {fc & duplexFull, fc & !duplexFull});
		end
	endtask

	// Main sequence
	initial begin
		doReset;
		for (i = 0; i < 4; i = i + 1) begin
			apb(1'b0, REGA[i], 8'h00);
			check(rdVal, 32'h0);
			apb(1'b1, REGA[i], 8'hFF);
			apb(1'b0, REGA[i], 8'h00);
			check(rdVal, {24'h0, REGM[i]});
		end
		apb(1'b0, 16'h1008, 8'h00);
		check({rdErr, rdVal[7:0]}, 9'h100);
		doReset;
		pauseFilterEn <= 1'b1;
		frame(BAD, 3'h0, 14'h0040, DRP);
		frame(5'h00, 3'h0, 14'h0040, FWD);
		frame(PS, 3'h0, 14'h0040, DRP);
		apb(1'b1, 16'h1004, 8'h01);
		frame(BAD, 3'h0, 14'h0040, MIR);
		frame(BAD | PS, 3'h0, 14'h0040, MIR);
		frame(PS, 3'h0, 14'h0040, DRP);
		pauseFilterEn <= 1'b0;
		frame(PS, 3'h0, 14'h0040, FWD);
		for (k = 0; k < 2; k = k + 1) begin
			doReset;
			apb(1'b1, 16'h1000, {6'h00, k[0], 1'b0});
			for (i = 0; i < 6; i = i + 1)
				frame(BC, 3'h0, 14'h0040, (k == 1 && i >= 4) ? DRP : FWD);
			check({31'h0, stormActive}, {31'h0, k[0]});
		end
		portFlowEn <= 1'b1;
		rate(8'h00, 5'h00, 3'h0, 14'h0050, 1'b1, FWD);
		rate(8'h00, 5'h00, 3'h0, 14'h0051, 1'b1, DRP);
		rate(8'h00, 5'h00, 3'h0, 14'h0051, 1'b0, FWD);
		rate(8'h02, 5'h00, 3'h0, 14'h0044, 1'b1, FWD);
		rate(8'h02, 5'h00, 3'h0, 14'h0045, 1'b1, DRP);
		rate(8'h01, 5'h00, 3'h0, 14'h0049, 1'b1, DRP);
		rate(8'h21, 5'h00, 3'h0, 14'h0049, 1'b1, FWD);
		rate(8'h40, 5'h00, 3'h3, 14'h0051, 1'b1, DRP);
		rate(8'h00, 5'h00, 3'h3, 14'h0051, 1'b1, FWD);
		// Class k is unicast, flooded, multicast, broadcast; mode m counts k >= m
		for (m = 0; m < 4; m = m + 1)
			for (k = 0; k < 4; k = k + 1)
				rate({4'h0, m[1:0], 2'h0}, (5'h01 << k) & 5'h0E, 3'h0, 14'h0051, 1'b1,
					(k >= m) ? DRP : FWD);
		for (k = 0; k < 4; k = k + 1) begin
			duplexFull <= k[0];
			portFlowEn <= k[1];
			rate(8'h10, 5'h00, 3'h0, 14'h0051, 1'b1, DRP);
		end
		fabricCongested <= 1'b1;
		for (k = 0; k < 4; k = k + 1) begin
			doReset;
			duplexFull <= k[0];
			apb(1'b1, 16'h1004, {4'h0, k[1], 3'h0});
			repeat (2) @(posedge clk);
			check({pauseReq, jamReq}, {k[0] & portFlowEn, !k[0] & k[1]});
		end
		finishTest;
	end
endmodule
